/* inc/swpu_cfg.svh */
// Constants for the SIMD word permute unit
`ifndef SWPU_CFG_SVH
`define SWPU_CFG_SVH
`define SWPU_NARROW_W   64
`define SWPU_WIDE_W     128
`define SWPU_GPR_W      32
`define SWPU_WORD_W     16
`define SWPU_DWORD_W    32
`define SWPU_IMM_W      8
`define SWPU_SEL_W      2
`define SWPU_OP_W       5
`define SWPU_HALF_W     64
`endif

/* inc/swpu_pkg.sv */
// Types for the SIMD word permute unit
`include "swpu_cfg.svh"
package swpu_pkg;
  typedef enum logic [`SWPU_OP_W-1:0] {
    SWPU_OP_INSERT_WORD    = 5'h00,
    SWPU_OP_EXTRACT_WORD   = 5'h01,
    SWPU_OP_MASK_NARROW    = 5'h02,
    SWPU_OP_MASK_WIDE      = 5'h03,
    SWPU_OP_SHUF_NARROW    = 5'h04,
    SWPU_OP_SHUF_LOW       = 5'h05,
    SWPU_OP_SHUF_HIGH      = 5'h06,
    SWPU_OP_SHUF_DWORD     = 5'h07,
    SWPU_OP_UNPACK_LOW_Q   = 5'h08,
    SWPU_OP_UNPACK_HIGH_Q  = 5'h09,
    SWPU_OP_NARROW_TO_WIDE = 5'h0a,
    SWPU_OP_WIDE_TO_NARROW = 5'h0b,
    SWPU_OP_CMPEQ_BYTE     = 5'h0c,
    SWPU_OP_CMPEQ_WORD     = 5'h0d,
    SWPU_OP_CMPEQ_DWORD    = 5'h0e,
    SWPU_OP_SUBUS_BYTE     = 5'h0f,
    SWPU_OP_SUBUS_WORD     = 5'h10,
    SWPU_OP_SRL_WORD       = 5'h11,
    SWPU_OP_SRL_DWORD      = 5'h12,
    SWPU_OP_SLL_WORD       = 5'h13,
    SWPU_OP_SLL_DWORD      = 5'h14,
    SWPU_OP_CVT_SP_TO_DW   = 5'h15,
    SWPU_OP_CVT_DW_TO_SP   = 5'h16,
    SWPU_OP_CVT_DP_TO_DW   = 5'h17,
    SWPU_OP_CVT_DW_TO_DP   = 5'h18
  } swpu_op_t;

  typedef struct packed {
    logic                       valid;
    swpu_op_t                   op;
    logic [`SWPU_IMM_W-1:0]     eight_bit_immediate;
    logic                       from_memory;
    logic [`SWPU_WIDE_W-1:0]    dst;
    logic [`SWPU_WIDE_W-1:0]    src;
    logic [`SWPU_WIDE_W-1:0]    mem;
    logic [`SWPU_GPR_W-1:0]     gpr;
  } swpu_req_t;

  typedef struct packed {
    logic                       valid;
    logic [`SWPU_WIDE_W-1:0]    data;
  } swpu_res_t;

  typedef struct packed {
    swpu_res_t res;
  } swpu_state_t;
endpackage

/* hw/swpu_core.sv */
// SIMD word permute unit datapath
`timescale 1ns/1ps
`include "swpu_cfg.svh"
module swpu_core
  import swpu_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      rst_n,
  input  wire swpu_req_t req,
  output swpu_res_t      res
);
  localparam int NB = `SWPU_WIDE_W / 8;
  localparam int NW = `SWPU_WIDE_W / `SWPU_WORD_W;
  localparam int ND = `SWPU_WIDE_W / `SWPU_DWORD_W;
  localparam int WW = `SWPU_WORD_W;
  localparam int DW = `SWPU_DWORD_W;
  localparam int HW = `SWPU_HALF_W;

  swpu_state_t state_reg;
  swpu_state_t state_next;

  logic [`SWPU_WIDE_W-1:0] opnd;
  logic [NB-1:0]           sign_bits;
  logic [`SWPU_WIDE_W-1:0] eq_b, eq_w, eq_d, sub_b, sub_w;
  logic [`SWPU_WIDE_W-1:0] srl_w, srl_d, sll_w, sll_d;
  logic [`SWPU_WIDE_W-1:0] cvt_sd, cvt_ds, cvt_pd, cvt_dp;
  logic [7:0]              cnt;

  assign opnd = req.from_memory ? req.mem : req.src;
  assign cnt  = opnd[7:0];

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_byte
      assign sign_bits[gi] = opnd[gi*8+7];
      assign eq_b[gi*8 +: 8] = (req.dst[gi*8 +: 8] == opnd[gi*8 +: 8]) ? 8'hff : 8'h00;
      assign sub_b[gi*8 +: 8] = (req.dst[gi*8 +: 8] > opnd[gi*8 +: 8]) ?
                                8'(req.dst[gi*8 +: 8] - opnd[gi*8 +: 8]) : 8'h00;
    end
    for (gi = 0; gi < NW; gi++) begin : g_word
      assign eq_w[gi*WW +: WW] = (req.dst[gi*WW +: WW] == opnd[gi*WW +: WW]) ?
                                 16'hffff : 16'h0000;
      assign sub_w[gi*WW +: WW] = (req.dst[gi*WW +: WW] > opnd[gi*WW +: WW]) ?
                                  16'(req.dst[gi*WW +: WW] - opnd[gi*WW +: WW]) : 16'h0000;
      assign srl_w[gi*WW +: WW] = (cnt >= 8'(WW)) ? 16'h0000 : req.dst[gi*WW +: WW] >> cnt;
      assign sll_w[gi*WW +: WW] = (cnt >= 8'(WW)) ? 16'h0000 : req.dst[gi*WW +: WW] << cnt;
    end
    for (gi = 0; gi < ND; gi++) begin : g_dword
      logic [DW-1:0] a;
      logic          sg;
      logic [7:0]    ex;
      logic [23:0]   mt;
      logic [DW-1:0] ab;
      logic [31:0]   fl;
      logic [DW-1:0] sd;
      assign a  = req.dst[gi*DW +: DW];
      assign eq_d[gi*DW +: DW] = (a == opnd[gi*DW +: DW]) ? 32'hffffffff : 32'h0;
      assign srl_d[gi*DW +: DW] = (cnt >= 8'(DW)) ? 32'h0 : a >> cnt;
      assign sll_d[gi*DW +: DW] = (cnt >= 8'(DW)) ? 32'h0 : a << cnt;
      // Truncating float to int; out of range gives the integer indefinite value
      assign sg = opnd[gi*DW+31];
      assign ex = opnd[gi*DW+23 +: 8];
      assign mt = {1'b1, opnd[gi*DW +: 23]};
      always_comb begin
        logic [DW-1:0] mag;
        mag = 32'h0;
        if (ex >= 8'h9e) begin
          mag = 32'h80000000;
        end else if (ex >= 8'h96) begin
          mag = {8'h00, mt} << (ex - 8'h96);
        end else if (ex >= 8'h7f) begin
          mag = {8'h00, mt >> (8'h96 - ex)};
        end
        sd = (ex >= 8'h9e) ? 32'h80000000 : (sg ? 32'(-mag) : mag);
      end
      // One driver per lane slice keeps the vector out of several processes
      assign cvt_sd[gi*DW +: DW] = sd;
      // Int to float, truncating the mantissa; simple and exact below 2^24
      assign ab = a[DW-1] ? 32'(-a) : a;
      always_comb begin
        int msb;
        msb = 0;
        for (int k = 0; k < DW; k++) begin
          if (ab[k]) begin
            msb = k;
          end
        end
        if (ab == 32'h0) begin
          fl = 32'h0;
        end else begin
          fl = {a[DW-1], 8'(msb + 127), 23'((ab << (DW - 1 - msb)) >> 8)};
        end
      end
      assign cvt_ds[gi*DW +: DW] = fl;
    end
    for (gi = 0; gi < 2; gi++) begin : g_dp
      logic [63:0]   d;
      logic [10:0]   ex;
      logic [52:0]   mt;
      logic [DW-1:0] mag;
      logic [DW-1:0] b;
      logic [DW-1:0] ab;
      logic [63:0]   dp;
      assign d  = opnd[gi*HW +: HW];
      assign ex = d[62:52];
      assign mt = {1'b1, d[51:0]};
      assign mag = (ex < 11'h3ff) ? 32'h0 : 32'(mt >> (11'h433 - ex));
      assign cvt_pd[gi*DW +: DW] = (ex >= 11'h41e) ? 32'h80000000 :
                                   (d[63] ? 32'(-mag) : mag);
      assign cvt_pd[HW + gi*DW +: DW] = 32'h0;
      assign b  = opnd[gi*DW +: DW];
      assign ab = b[DW-1] ? 32'(-b) : b;
      always_comb begin
        int msb;
        msb = 0;
        for (int k = 0; k < DW; k++) begin
          if (ab[k]) begin
            msb = k;
          end
        end
        if (ab == 32'h0) begin
          dp = 64'h0;
        end else begin
          dp = {b[DW-1], 11'(msb + 1023), 52'({20'h0, ab} << (52 - msb))};
        end
      end
      assign cvt_dp[gi*HW +: HW] = dp;
    end
  endgenerate

  function automatic logic [HW-1:0] shuf4(input logic [HW-1:0] s,
                                          input logic [`SWPU_IMM_W-1:0] imm);
    logic [HW-1:0] r;
    r = '0;
    for (int k = 0; k < 4; k++) begin
      r[k*WW +: WW] = s[imm[k*2 +: 2]*WW +: WW];
    end
    return r;
  endfunction

  always_comb begin
    logic [`SWPU_WIDE_W-1:0] r;
    logic [`SWPU_SEL_W-1:0]  lane;
    r = req.dst;
    lane = req.eight_bit_immediate[`SWPU_SEL_W-1:0];
    state_next = state_reg;
    unique case (req.op)
      SWPU_OP_INSERT_WORD: begin
        // Other lanes come from dst untouched
        r[lane*WW +: WW] = req.from_memory ? req.mem[WW-1:0] : req.gpr[WW-1:0];
        r[`SWPU_WIDE_W-1:HW] = req.dst[`SWPU_WIDE_W-1:HW];
      end
      SWPU_OP_EXTRACT_WORD: r = {112'h0, opnd[lane*WW +: WW]};
      SWPU_OP_MASK_NARROW: r = {120'h0, sign_bits[7:0]};
      SWPU_OP_MASK_WIDE: r = {112'h0, sign_bits};
      SWPU_OP_SHUF_NARROW: r = {64'h0, shuf4(opnd[HW-1:0], req.eight_bit_immediate)};
      SWPU_OP_SHUF_LOW: r = {opnd[2*HW-1:HW], shuf4(opnd[HW-1:0], req.eight_bit_immediate)};
      SWPU_OP_SHUF_HIGH: r = {shuf4(opnd[2*HW-1:HW], req.eight_bit_immediate), opnd[HW-1:0]};
      SWPU_OP_SHUF_DWORD: begin
        for (int k = 0; k < ND; k++) begin
          r[k*DW +: DW] = opnd[req.eight_bit_immediate[k*2 +: 2]*DW +: DW];
        end
      end
      SWPU_OP_UNPACK_LOW_Q: r = {opnd[HW-1:0], req.dst[HW-1:0]};
      SWPU_OP_UNPACK_HIGH_Q: r = {opnd[2*HW-1:HW], req.dst[2*HW-1:HW]};
      SWPU_OP_NARROW_TO_WIDE: r = {64'h0, opnd[HW-1:0]};
      SWPU_OP_WIDE_TO_NARROW: r = {64'h0, opnd[HW-1:0]};
      SWPU_OP_CMPEQ_BYTE: r = eq_b;
      SWPU_OP_CMPEQ_WORD: r = eq_w;
      SWPU_OP_CMPEQ_DWORD: r = eq_d;
      SWPU_OP_SUBUS_BYTE: r = sub_b;
      SWPU_OP_SUBUS_WORD: r = sub_w;
      SWPU_OP_SRL_WORD: r = srl_w;
      SWPU_OP_SRL_DWORD: r = srl_d;
      SWPU_OP_SLL_WORD: r = sll_w;
      SWPU_OP_SLL_DWORD: r = sll_d;
      SWPU_OP_CVT_SP_TO_DW: r = cvt_sd;
      SWPU_OP_CVT_DW_TO_SP: r = cvt_ds;
      SWPU_OP_CVT_DP_TO_DW: r = cvt_pd;
      SWPU_OP_CVT_DW_TO_DP: r = cvt_dp;
      // Unassigned codes, such as a doubleword saturating subtract, pass dst
      default: r = req.dst;
    endcase
    state_next.res.valid = req.valid;
    if (req.valid) begin
      state_next.res.data = r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign res = state_reg.res;

  property p_latency;
    @(posedge sys_clk) disable iff (!rst_n) req.valid |=> res.valid;
  endproperty
  a_latency: assert property (p_latency) else $error("result not one cycle after issue");

  logic [1:0] lane_q;
  assign lane_q = req.eight_bit_immediate[1:0];

  property p_insert;
    @(posedge sys_clk) disable iff (!rst_n)
      (req.valid && req.op == SWPU_OP_INSERT_WORD && !req.from_memory) |=>
      res.data[$past(lane_q)*WW +: WW] == $past(req.gpr[WW-1:0]);
  endproperty
  a_insert: assert property (p_insert) else $error("insert lane wrong");

  property p_mask_n;
    @(posedge sys_clk) disable iff (!rst_n)
      (req.valid && req.op == SWPU_OP_MASK_NARROW) |=> res.data[`SWPU_WIDE_W-1:8] == '0;
  endproperty
  a_mask_n: assert property (p_mask_n) else $error("narrow mask upper bits set");

  property p_mask_w;
    @(posedge sys_clk) disable iff (!rst_n)
      (req.valid && req.op == SWPU_OP_MASK_WIDE) |=>
      res.data[15:0] == $past(sign_bits) && res.data[`SWPU_WIDE_W-1:16] == '0;
  endproperty
  a_mask_w: assert property (p_mask_w) else $error("wide mask wrong");

  property p_n2w;
    @(posedge sys_clk) disable iff (!rst_n)
      (req.valid && req.op == SWPU_OP_NARROW_TO_WIDE) |=> res.data[`SWPU_WIDE_W-1:HW] == '0;
  endproperty
  a_n2w: assert property (p_n2w) else $error("wide high half not zero");

  property p_shuf_lo;
    @(posedge sys_clk) disable iff (!rst_n)
      (req.valid && req.op == SWPU_OP_SHUF_LOW) |=>
      res.data[`SWPU_WIDE_W-1:HW] == $past(opnd[`SWPU_WIDE_W-1:HW]);
  endproperty
  a_shuf_lo: assert property (p_shuf_lo) else $error("high half not passed");

  property p_extract;
    @(posedge sys_clk) disable iff (!rst_n)
      (req.valid && req.op == SWPU_OP_EXTRACT_WORD) |=> res.data[`SWPU_WIDE_W-1:WW] == '0;
  endproperty
  a_extract: assert property (p_extract) else $error("extract not zero-extended");

  property p_cmpself;
    @(posedge sys_clk) disable iff (!rst_n)
      (req.valid && req.op == SWPU_OP_CMPEQ_WORD && req.dst == opnd) |=> &res.data;
  endproperty
  a_cmpself: assert property (p_cmpself) else $error("self compare not all ones");

  property p_unpack;
    @(posedge sys_clk) disable iff (!rst_n)
      (req.valid && req.op == SWPU_OP_UNPACK_LOW_Q) |=>
      res.data == {$past(opnd[HW-1:0]), $past(req.dst[HW-1:0])};
  endproperty
  a_unpack: assert property (p_unpack) else $error("low interleave wrong");
endmodule

/* testbench/swpu_pipe_model.sv */
// Pipeline-side model that issues requests to the permute unit
`timescale 1ns/1ps
module swpu_pipe_model
  import swpu_pkg::*;
(
  input  wire logic sys_clk,
  output swpu_req_t req
);
  initial req = '0;
  // One request per call; calls in a row give every-cycle traffic
  task automatic issue(input swpu_req_t r);
    @(posedge sys_clk);
    #1;
    req = r;
    req.valid = 1'b1;
  endtask
  // Idle cycle; operands scrambled so stale data is never trusted
  task automatic idle();
    @(posedge sys_clk);
    #1;
    req = swpu_req_t'(~req);
    req.valid = 1'b0;
  endtask
endmodule

/* testbench/test_simd_word_permute_unit.sv */
// Self-checking bench for the SIMD word permute unit
`timescale 1ns/1ps
module test_simd_word_permute_unit
  import swpu_pkg::*;
();
  logic         sys_clk;
  logic         rst_n;
  swpu_req_t    req;
  swpu_res_t    res;
  logic         pend;
  logic [127:0] pexp;
  logic [31:0]  seed = 32'h0000000e;
  int           n_errors = 0;
  int           checked = 0;

  swpu_pipe_model pipe (.sys_clk(sys_clk), .req(req));
  swpu_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .res(res));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Advance a full word per call so successive values are not shifted copies
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++) seed = {seed[30:0], seed[31]^seed[21]^seed[1]^seed[0]};
    return seed;
  endfunction

  function automatic logic [127:0] expv(swpu_req_t r);
    logic [127:0] o, d, x, m, a, b, y;
    logic [7:0]   im;
    int           w, k, c;
    o = r.from_memory ? r.mem : r.src;
    d = r.dst;
    im = r.eight_bit_immediate;
    x = '0;
    w = 0;
    case (r.op)
      SWPU_OP_INSERT_WORD: begin
        x = d;
        x[16*im[1:0] +: 16] = r.from_memory ? r.mem[15:0] : r.gpr[15:0];
      end
      SWPU_OP_EXTRACT_WORD: x[15:0] = o[16*im[1:0] +: 16];
      SWPU_OP_MASK_NARROW: for (k = 0; k < 8; k++) x[k] = o[8*k+7];
      SWPU_OP_MASK_WIDE: for (k = 0; k < 16; k++) x[k] = o[8*k+7];
      SWPU_OP_SHUF_NARROW, SWPU_OP_SHUF_LOW, SWPU_OP_SHUF_HIGH: begin
        c = (r.op == SWPU_OP_SHUF_HIGH) ? 64 : 0;
        x = (r.op == SWPU_OP_SHUF_NARROW) ? '0 : o;
        for (k = 0; k < 4; k++) x[c+16*k +: 16] = o[c+16*im[2*k +: 2] +: 16];
      end
      SWPU_OP_SHUF_DWORD: for (k = 0; k < 4; k++) x[32*k +: 32] = o[32*im[2*k +: 2] +: 32];
      SWPU_OP_UNPACK_LOW_Q: x = {o[63:0], d[63:0]};
      SWPU_OP_UNPACK_HIGH_Q: x = {o[127:64], d[127:64]};
      SWPU_OP_NARROW_TO_WIDE, SWPU_OP_WIDE_TO_NARROW: x[63:0] = o[63:0];
      SWPU_OP_CVT_DW_TO_DP: for (k = 0; k < 2; k++)
        x[64*k +: 64] = $realtobits($itor($signed(o[32*k +: 32])));
      SWPU_OP_CMPEQ_BYTE, SWPU_OP_SUBUS_BYTE: w = 8;
      SWPU_OP_CMPEQ_WORD, SWPU_OP_SUBUS_WORD, SWPU_OP_SRL_WORD, SWPU_OP_SLL_WORD: w = 16;
      SWPU_OP_CMPEQ_DWORD, SWPU_OP_SRL_DWORD, SWPU_OP_SLL_DWORD: w = 32;
      default: x = d;
    endcase
    m = (128'h1 << w) - 128'h1;
    c = int'(o[7:0]);
    for (k = 0; w > 0 && k < 128 / w; k++) begin
      a = (d >> (k*w)) & m;
      b = (o >> (k*w)) & m;
      case (r.op)
        SWPU_OP_CMPEQ_BYTE, SWPU_OP_CMPEQ_WORD, SWPU_OP_CMPEQ_DWORD: y = (a == b) ? m : '0;
        SWPU_OP_SUBUS_BYTE, SWPU_OP_SUBUS_WORD: y = (a > b) ? a - b : '0;
        SWPU_OP_SRL_WORD, SWPU_OP_SRL_DWORD: y = (c >= w) ? '0 : a >> c;
        default: y = (c >= w) ? '0 : (a << c) & m;
      endcase
      x = x | (y << (k*w));
    end
    return x;
  endfunction

  task automatic check(input string what, input logic [127:0] e, input logic [127:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Expected result follows each taken request by one edge
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
      pexp <= '0;
    end else begin
      pend <= req.valid;
      if (req.valid === 1'b1) pexp <= expv(req);
    end
  end

  // Data must also hold between issues, so it is compared every cycle
  always @(posedge sys_clk) begin
    #2;
    if (rst_n === 1'b1) begin
      check("res.valid", {127'h0, pend}, {127'h0, res.valid});
      check("res.data", pexp, res.data);
    end
  end

  // Mode 1 feeds a register against itself, mode 2 keeps shift counts small
  task automatic run(input swpu_op_t op, input int n, input int mode);
    swpu_req_t  r;
    logic [31:0] v;
    for (int i = 0; i < n; i++) begin
      v = rnd();
      r = {1'b1, op, v[7:0], v[8], rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(),
           rnd(), rnd(), rnd(), rnd(), rnd()};
      if (mode == 1) r.src = r.dst;
      if (mode == 1) r.mem = r.dst;
      if (mode == 2) r.src[7:0] = 8'(v[31:16] % 36);
      if (mode == 2) r.mem[7:0] = 8'(v[31:16] % 36);
      pipe.issue(r);
      if (v[11:10] == 2'h0) pipe.idle();
    end
  endtask

  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    run(SWPU_OP_INSERT_WORD, 24, 0);
    run(SWPU_OP_EXTRACT_WORD, 12, 0);
    run(SWPU_OP_MASK_NARROW, 8, 0);
    run(SWPU_OP_MASK_WIDE, 8, 0);
    run(SWPU_OP_SHUF_NARROW, 16, 0);
    run(SWPU_OP_SHUF_LOW, 10, 0);
    run(SWPU_OP_SHUF_HIGH, 10, 0);
    run(SWPU_OP_SHUF_DWORD, 12, 0);
    run(SWPU_OP_UNPACK_LOW_Q, 8, 0);
    run(SWPU_OP_UNPACK_HIGH_Q, 8, 0);
    run(SWPU_OP_NARROW_TO_WIDE, 6, 0);
    run(SWPU_OP_WIDE_TO_NARROW, 6, 0);
    run(SWPU_OP_CMPEQ_BYTE, 4, 1);
    run(SWPU_OP_CMPEQ_WORD, 4, 1);
    run(SWPU_OP_CMPEQ_DWORD, 4, 1);
    run(SWPU_OP_SUBUS_BYTE, 8, 0);
    run(SWPU_OP_SUBUS_WORD, 8, 0);
    run(SWPU_OP_SRL_WORD, 8, 2);
    run(SWPU_OP_SRL_DWORD, 8, 2);
    run(SWPU_OP_SLL_WORD, 8, 2);
    run(SWPU_OP_SLL_DWORD, 8, 2);
    run(SWPU_OP_CVT_DW_TO_DP, 8, 0);
    run(swpu_op_t'(5'h1f), 4, 0);
    pipe.idle();
    rst_n = 1'b0;
    #1;
    check("reset res", '0, {res.data[127:1], res.valid});
    @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    run(SWPU_OP_SHUF_NARROW, 4, 0);
    pipe.idle();
    pipe.idle();
    report_and_stop();
  end
endmodule
